// ### verilog/uart_irq_cfg.svh
// Constants of the UART interrupt enable, priority and status logic
`ifndef UART_IRQ_CFG_SVH
`define UART_IRQ_CFG_SVH
// Mask register bit positions
`define IRQ_MASK_RX_BIT 0
`define IRQ_MASK_TX_BIT 1
`define IRQ_MASK_LINE_BIT 2
`define IRQ_MASK_MODEM_BIT 3
`define IRQ_MASK_SLEEP_BIT 4
`define IRQ_MASK_XOFF_BIT 5
`define IRQ_MASK_RTS_BIT 6
`define IRQ_MASK_CTS_BIT 7
`define IRQ_MASK_RESET 8'h00
// Source codes in bits 5..0
`define SRC_CODE_LINE 6'h06
`define SRC_CODE_TIMEOUT 6'h0C
`define SRC_CODE_RX 6'h04
`define SRC_CODE_TX 6'h02
`define SRC_CODE_MODEM 6'h00
`define SRC_CODE_FLOWCHAR 6'h10
`define SRC_CODE_HANDSHAKE 6'h20
`define SRC_CODE_NONE 6'h01
`define IRQ_SOURCE_RESET 8'h01
// Receive time-out: four characters plus twelve bits
`define TIMEOUT_CHARS 4
`define TIMEOUT_EXTRA_BITS 12
`endif

// ### verilog/uart_irq_pkg.sv
// Types of the UART interrupt enable, priority and status logic
package uart_irq_pkg;
  // Pending sources in priority order, index 0 highest
  typedef enum logic [2:0] {
    SRC_LINE = 3'h0,
    SRC_TIMEOUT = 3'h1,
    SRC_RX = 3'h2,
    SRC_TX = 3'h3,
    SRC_MODEM = 3'h4,
    SRC_FLOWCHAR = 3'h5,
    SRC_HANDSHAKE = 3'h6,
    SRC_NONE = 3'h7
  } src_sel_t;

  // Receive side status from the FIFO and receiver
  typedef struct packed {
    logic fifo_at_trigger;
    logic char_pushed;
    logic fifo_empty;
    logic overrun;
    logic [2:0] head_errors;
    logic push_errors;
    logic any_fifo_error;
  } rx_stat_t;

  // Transmit side status
  typedef struct packed {
    logic below_trigger;
    logic holding_empty;
    logic all_empty;
  } tx_stat_t;

  // Host access strobes, one cycle each
  typedef struct packed {
    logic mask_wr;
    logic source_rd;
    logic line_rd;
    logic modem_rd;
    logic holding_rd;
    logic holding_wr;
    logic gpio_level_rd;
  } host_strobe_t;
endpackage : uart_irq_pkg

// ### verilog/uart_irq_ctrl.sv
// Interrupt enable, prioritisation, status and clearing of a serial UART
// Operation
// [R1] FIFO mode: receive interrupt and code follow fill at or above trigger.
// [R2] Data ready flag sets on char push, clears only when FIFO empty.
// [R3] FIFOs on and mask bits 0-3 zero gives polled mode.
// [R4] Line status: overrun, head errors 2-4, tx empty, all empty, FIFO error.
// [R5] Mask bit 0 enables receive ready; holding full or trigger reached.
// [R6] Mask bit 1 enables transmit ready; setting it while empty raises it.
// [R7] Mask bit 2: overrun or head error raises line status; read clears.
// [R8] Enhanced select bit 6 reports errors when char enters FIFO.
// [R9] Mask bit 3: modem status bits 0-3 raise interrupt; read clears.
// [R10] Mask bits 4-7 need enhanced bit 4; sleep and stop-char enable.
// [R11] Mask bit 6: own request-to-send rising under auto flow control.
// [R12] Mask bit 7: clear-to-send input rising under auto flow control.
// [R13] Status read reports only highest pending source, rest stay queued; the read clears tx, flow and wake flags even when not reported.
// [R14] Time-out after four chars plus twelve bits; holding read clears.
// [R15] Transmit ready clears on status read or holding write.
// [R16] Flow chars raise interrupt; special also clears on next char.
// [R17] Handshake interrupts clear on modem status read only.
// [R18] Wake-up raises interrupt, status read clears, code as none.
// [R19] General input asserted with chosen polarity; level read clears.
// [R20] Codes: line 000110, timeout 001100, rx 000100, tx 000010.
// [R21] Codes: modem 000000, flow 010000, handshake 100000, none 000001.
// [R22] Status bit 0 low when pending, high when idle and at reset; a pending wake-up or general input interrupt leaves it high.
// [R23] Bit 7 FIFO enable; bit 6 inverts it on general input interrupt.
// [R24] Without enhanced bit, mask bits 4-7 ignore writes, stay off.
`include "uart_irq_cfg.svh"
module uart_irq_ctrl #(
  parameter int GPIO_W = 8,
  parameter int TIMER_W = 16
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [7:0] wdata_in,
  input wire uart_irq_pkg::host_strobe_t strobe_in,
  input wire uart_irq_pkg::rx_stat_t rx_in,
  input wire uart_irq_pkg::tx_stat_t tx_in,
  input wire logic fifo_en_in,
  input wire logic enhanced_en_in,
  input wire logic auto_rts_en_in,
  input wire logic auto_cts_en_in,
  input wire logic early_error_in,
  input wire logic wake_irq_en_in,
  input wire logic woke_in,
  input wire logic [3:0] modem_change_in,
  input wire logic xon_seen_in,
  input wire logic xoff_seen_in,
  input wire logic special_seen_in,
  input wire logic rts_level_in,
  input wire logic cts_pin_in,
  input wire logic [GPIO_W-1:0] gpio_pin_in,
  input wire logic [GPIO_W-1:0] gpio_irq_en_in,
  input wire logic [GPIO_W-1:0] gpio_invert_in,
  input wire logic [TIMER_W-1:0] bit_ticks_in,
  input wire logic [3:0] char_bits_in,
  output logic [7:0] irq_mask_out,
  output logic [7:0] irq_source_out,
  output logic [7:0] line_state_out,
  output logic polled_mode_out,
  output logic sleep_en_out,
  output logic irq_out
);
  localparam logic [TIMER_W-1:0] TO_CHARS = TIMER_W'(`TIMEOUT_CHARS);
  localparam logic [TIMER_W-1:0] TO_EXTRA = TIMER_W'(`TIMEOUT_EXTRA_BITS);

  logic [7:0] irq_mask_ff;
  logic [7:0] nxt_irq_mask;
  logic [7:0] irq_source_ff;
  logic [7:0] line_state_ff;
  logic polled_ff;
  logic irq_ff;
  logic data_ready_ff;
  logic nxt_data_ready;
  logic overrun_ff;
  logic [2:0] head_err_ff;
  logic early_err_ff;
  logic tx_irq_ff;
  logic tx_empty_d_ff;
  logic modem_irq_ff;
  logic flow_irq_ff;
  logic special_irq_ff;
  logic hs_irq_ff;
  logic rts_d_ff;
  logic wake_irq_ff;
  logic timeout_ff;
  logic [TIMER_W-1:0] timer_ff;
  logic [GPIO_W-1:0] gpio_s1_ff;
  logic [GPIO_W-1:0] gpio_s2_ff;
  logic [GPIO_W-1:0] gpio_act_d_ff;
  logic [GPIO_W-1:0] gpio_irq_ff;
  logic cts_s1_ff;
  logic cts_s2_ff;
  logic cts_d_ff;

  wire enh = enhanced_en_in;
  wire [GPIO_W-1:0] gpio_act = gpio_s2_ff ^ gpio_invert_in;
  wire [GPIO_W-1:0] gpio_rise = gpio_act & ~gpio_act_d_ff;
  wire gpio_pend = |(gpio_irq_ff & gpio_irq_en_in);
  wire line_err = overrun_ff | (|head_err_ff) | early_err_ff;
  wire line_pend = irq_mask_ff[`IRQ_MASK_LINE_BIT] & line_err; // [R7] [R8]
  wire rx_cond = fifo_en_in ? rx_in.fifo_at_trigger : data_ready_ff; // [R1] [R5]
  wire rx_pend = irq_mask_ff[`IRQ_MASK_RX_BIT] & rx_cond; // [R1] [R5]
  wire to_pend = irq_mask_ff[`IRQ_MASK_RX_BIT] & timeout_ff; // [R14]
  wire tx_cond = fifo_en_in ? (tx_in.below_trigger | tx_in.all_empty) : tx_in.holding_empty;
  wire tx_pend = irq_mask_ff[`IRQ_MASK_TX_BIT] & tx_irq_ff;
  wire modem_pend = irq_mask_ff[`IRQ_MASK_MODEM_BIT] & modem_irq_ff; // [R9]
  wire flow_pend = enh & irq_mask_ff[`IRQ_MASK_XOFF_BIT] & (flow_irq_ff | special_irq_ff);
  wire hs_pend = enh & hs_irq_ff; // [R11] [R12]
  wire wake_pend = wake_irq_en_in & wake_irq_ff; // [R18]
  wire rts_rise = rts_level_in & ~rts_d_ff & auto_rts_en_in & irq_mask_ff[`IRQ_MASK_RTS_BIT];
  wire cts_rise = cts_s2_ff & ~cts_d_ff & auto_cts_en_in & irq_mask_ff[`IRQ_MASK_CTS_BIT];
  wire tx_set = (tx_cond & ~tx_empty_d_ff) // [R6]
    | (strobe_in.mask_wr & wdata_in[`IRQ_MASK_TX_BIT] & ~irq_mask_ff[`IRQ_MASK_TX_BIT] & tx_cond);
  wire tx_clr = strobe_in.source_rd | strobe_in.holding_wr; // [R15]
  wire [TIMER_W-1:0] char_ticks = TIMER_W'(bit_ticks_in * char_bits_in);
  wire [TIMER_W-1:0] to_limit = TIMER_W'(char_ticks * TO_CHARS + bit_ticks_in * TO_EXTRA);
  wire timer_run = fifo_en_in & ~data_ready_ff ? 1'b0 : (fifo_en_in & ~rx_in.fifo_empty);

  // Highest priority source wins; lower ones stay pending in their flags
  wire uart_irq_pkg::src_sel_t sel = line_pend ? uart_irq_pkg::SRC_LINE : // [R13]
    to_pend ? uart_irq_pkg::SRC_TIMEOUT :
    rx_pend ? uart_irq_pkg::SRC_RX :
    tx_pend ? uart_irq_pkg::SRC_TX :
    modem_pend ? uart_irq_pkg::SRC_MODEM :
    flow_pend ? uart_irq_pkg::SRC_FLOWCHAR :
    hs_pend ? uart_irq_pkg::SRC_HANDSHAKE : uart_irq_pkg::SRC_NONE;
  logic [5:0] code;
  always_comb begin
    case (sel)
      uart_irq_pkg::SRC_LINE: code = `SRC_CODE_LINE; // [R20]
      uart_irq_pkg::SRC_TIMEOUT: code = `SRC_CODE_TIMEOUT; // [R20]
      uart_irq_pkg::SRC_RX: code = `SRC_CODE_RX; // [R20]
      uart_irq_pkg::SRC_TX: code = `SRC_CODE_TX; // [R20]
      uart_irq_pkg::SRC_MODEM: code = `SRC_CODE_MODEM; // [R21]
      uart_irq_pkg::SRC_FLOWCHAR: code = `SRC_CODE_FLOWCHAR; // [R21]
      uart_irq_pkg::SRC_HANDSHAKE: code = `SRC_CODE_HANDSHAKE; // [R21]
      default: code = `SRC_CODE_NONE; // [R18] [R21] [R22]
    endcase
  end
  wire any_pend = (sel != uart_irq_pkg::SRC_NONE) | wake_pend | gpio_pend; // [R19]
  wire bit7 = fifo_en_in; // [R23]
  wire bit6 = bit7 ^ gpio_pend; // [R23]
  wire [7:0] nxt_source = {bit7, bit6, code};

  // Mask writes: upper half only with the enhanced bit set
  always_comb begin
    nxt_irq_mask = irq_mask_ff;
    if (strobe_in.mask_wr) begin
      nxt_irq_mask[3:0] = wdata_in[3:0];
      if (enh) begin
        nxt_irq_mask[7:4] = wdata_in[7:4]; // [R10]
      end
    end
    if (!enh) begin
      nxt_irq_mask[7:4] = 4'h0; // [R24]
    end
  end

  // Data ready: a push wins over the empty-clear in the same cycle
  always_comb begin
    nxt_data_ready = data_ready_ff;
    if (rx_in.fifo_empty) begin
      nxt_data_ready = 1'b0; // [R2]
    end
    if (rx_in.char_pushed) begin
      nxt_data_ready = 1'b1; // [R2]
    end
  end

  wire [7:0] nxt_line = {rx_in.any_fifo_error, tx_in.all_empty, tx_in.holding_empty,
    head_err_ff[2], head_err_ff[1], head_err_ff[0], overrun_ff, data_ready_ff}; // [R4]

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      irq_mask_ff <= `IRQ_MASK_RESET;
      irq_source_ff <= `IRQ_SOURCE_RESET;
      line_state_ff <= 8'h00;
      polled_ff <= 1'b0;
      irq_ff <= 1'b0;
      data_ready_ff <= 1'b0;
    end else begin
      irq_mask_ff <= nxt_irq_mask;
      irq_source_ff <= nxt_source;
      line_state_ff <= nxt_line;
      polled_ff <= fifo_en_in & (irq_mask_ff[3:0] == 4'h0); // [R3]
      irq_ff <= any_pend;
      data_ready_ff <= nxt_data_ready;
    end
  end

  // Line status error flags; new events win over the clearing read
  wire line_keep = ~strobe_in.line_rd; // [R7]
  wire nxt_overrun = rx_in.overrun | (overrun_ff & line_keep); // [R7]
  wire [2:0] nxt_head_err = rx_in.head_errors | (head_err_ff & {3{line_keep}}); // [R7]
  wire nxt_early_err = (early_error_in & rx_in.push_errors) // [R8]
    | (early_err_ff & line_keep);
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      overrun_ff <= 1'b0;
      head_err_ff <= 3'h0;
      early_err_ff <= 1'b0;
    end else begin
      overrun_ff <= nxt_overrun;
      head_err_ff <= nxt_head_err;
      early_err_ff <= nxt_early_err;
    end
  end

  // Source flags; an event in the same cycle wins over its clear
  wire nxt_tx_irq = tx_set | (tx_irq_ff & ~tx_clr); // [R6] [R15]
  wire nxt_modem_irq = (|modem_change_in) | (modem_irq_ff & ~strobe_in.modem_rd); // [R9]
  wire nxt_flow_irq = xon_seen_in | xoff_seen_in // [R16]
    | (flow_irq_ff & ~strobe_in.source_rd);
  wire special_keep = ~strobe_in.source_rd & ~rx_in.char_pushed; // [R16]
  wire nxt_special_irq = special_seen_in | (special_irq_ff & special_keep); // [R16]
  wire nxt_wake_irq = woke_in | (wake_irq_ff & ~strobe_in.source_rd); // [R18]
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      tx_irq_ff <= 1'b0;
      tx_empty_d_ff <= 1'b0;
      modem_irq_ff <= 1'b0;
      flow_irq_ff <= 1'b0;
      special_irq_ff <= 1'b0;
      wake_irq_ff <= 1'b0;
    end else begin
      tx_irq_ff <= nxt_tx_irq;
      tx_empty_d_ff <= tx_cond;
      modem_irq_ff <= nxt_modem_irq;
      flow_irq_ff <= nxt_flow_irq;
      special_irq_ff <= nxt_special_irq;
      wake_irq_ff <= nxt_wake_irq;
    end
  end

  // Handshake edges; the clear-to-send pin is synchronised first
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      hs_irq_ff <= 1'b0;
      rts_d_ff <= 1'b0;
      cts_s1_ff <= 1'b0;
      cts_s2_ff <= 1'b0;
      cts_d_ff <= 1'b0;
    end else begin
      hs_irq_ff <= rts_rise | cts_rise | (hs_irq_ff & ~strobe_in.modem_rd); // [R11] [R12] [R17]
      rts_d_ff <= rts_level_in;
      cts_s1_ff <= cts_pin_in;
      cts_s2_ff <= cts_s1_ff;
      cts_d_ff <= cts_s2_ff;
    end
  end

  // Receive time-out timer restarts on every push or holding read
  // Expiry is a one-cycle event as the timer reaches the limit, so a
  // holding read of a saturated timer clears the flag until the restarted timer expires again
  wire to_restart = rx_in.char_pushed | strobe_in.holding_rd | ~timer_run; // [R14]
  wire to_count = ~to_restart & (timer_ff != to_limit);
  wire to_expire = ~to_restart & (timer_ff == to_limit - TIMER_W'(1)); // [R14]
  wire nxt_timeout = to_expire // [R14]
    | (timeout_ff & ~strobe_in.holding_rd & ~rx_in.fifo_empty);
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      timer_ff <= '0;
      timeout_ff <= 1'b0;
    end else begin
      if (to_restart) begin
        timer_ff <= '0;
      end else if (to_count) begin
        timer_ff <= timer_ff + TIMER_W'(1);
      end
      timeout_ff <= nxt_timeout;
    end
  end

  genvar g;
  generate
    for (g = 0; g < GPIO_W; g++) begin : gen_gpio
      always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
          gpio_s1_ff[g] <= 1'b0;
          gpio_s2_ff[g] <= 1'b0;
          gpio_act_d_ff[g] <= 1'b0;
          gpio_irq_ff[g] <= 1'b0;
        end else begin
          gpio_s1_ff[g] <= gpio_pin_in[g];
          gpio_s2_ff[g] <= gpio_s1_ff[g];
          gpio_act_d_ff[g] <= gpio_act[g];
          gpio_irq_ff[g] <= gpio_rise[g] // [R19]
            | (gpio_irq_ff[g] & ~strobe_in.gpio_level_rd);
        end
      end
    end
  endgenerate

  assign irq_mask_out = irq_mask_ff;
  assign irq_source_out = irq_source_ff;
  assign line_state_out = line_state_ff;
  assign polled_mode_out = polled_ff;
  assign sleep_en_out = irq_mask_ff[`IRQ_MASK_SLEEP_BIT]; // [R10]
  assign irq_out = irq_ff;
endmodule : uart_irq_ctrl

// ### test/uart_irq_ctrl_properties.sv
// Port-level checks of the UART interrupt controller
module uart_irq_ctrl_checker (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [7:0] wdata_in,
  input wire uart_irq_pkg::host_strobe_t strobe_in,
  input wire uart_irq_pkg::rx_stat_t rx_in,
  input wire logic fifo_en_in,
  input wire logic enhanced_en_in,
  input wire logic [7:0] irq_mask_out,
  input wire logic [7:0] irq_source_out,
  input wire logic [7:0] line_state_out,
  input wire logic polled_mode_out,
  input wire logic irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  sequence overrun_armed;
    rx_in.overrun && irq_mask_out[2];
  endsequence
  sequence line_reported;
    irq_source_out[5:0] == 6'h06 && irq_out;
  endsequence
  line_raise_a: assert property (overrun_armed |-> ##2 line_reported)
    else $error("overrun not reported");
  pend_irq_a: assert property (!irq_source_out[0] |-> irq_out)
    else $error("pending code without interrupt");
  fifo_flag_a: assert property (!$past(rst_in) |-> irq_source_out[7] == $past(fifo_en_in))
    else $error("fifo enable bit wrong");
  polled_mode_a: assert property ((fifo_en_in && irq_mask_out[3:0] == 4'h0) [*2] |-> polled_mode_out)
    else $error("polled mode missing");
  upper_lock_a: assert property ((!enhanced_en_in) [*2] |-> irq_mask_out[7:4] == 4'h0)
    else $error("upper mask bits open");
  mask_write_a: assert property (strobe_in.mask_wr |=>
    (irq_mask_out & 8'h0F) == ($past(wdata_in) & 8'h0F))
    else $error("mask write lost");
  data_ready_a: assert property (rx_in.char_pushed |-> ##2 line_state_out[0])
    else $error("data ready not set");
  empty_ready_a: assert property ((rx_in.fifo_empty && !rx_in.char_pushed) [*3] |->
    !line_state_out[0])
    else $error("data ready stuck");
endmodule : uart_irq_ctrl_checker

bind uart_irq_ctrl uart_irq_ctrl_checker i_checker (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .wdata_in(wdata_in), .strobe_in(strobe_in),
  .rx_in(rx_in), .fifo_en_in(fifo_en_in), .enhanced_en_in(enhanced_en_in),
  .irq_mask_out(irq_mask_out), .irq_source_out(irq_source_out),
  .line_state_out(line_state_out), .polled_mode_out(polled_mode_out), .irq_out(irq_out)
);

// ### test/uart_host_model.sv
// Host processor model making one-cycle register access strobes
module uart_host_model (
  input wire logic clk_sys_in,
  output uart_irq_pkg::host_strobe_t strobe_out,
  output logic [7:0] wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial strobe_out = '0;
  initial wdata_out = 8'h00;
  // Released data bus shows the inverse, never the stale value
  task automatic access(input logic [6:0] sel, input logic [7:0] data);
    @(posedge clk_sys_in);
    strobe_out <= sel;
    wdata_out <= data;
    @(posedge clk_sys_in);
    strobe_out <= '0;
    wdata_out <= ~data;
  endtask : access
endmodule : uart_host_model

// ### test/uart_irq_ctrl_test.sv
// Self-checking testbench of the UART interrupt controller
module uart_irq_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TMO = 2 * (4 * 10 + 12);
  int fails = 0;
  int check_count = 0;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  uart_irq_pkg::host_strobe_t strobe_in;
  logic [7:0] wdata_in;
  uart_irq_pkg::rx_stat_t rx_in = 9'h040;
  uart_irq_pkg::tx_stat_t tx_in = 3'h0;
  logic fifo_en_in = 1'b1, enhanced_en_in = 1'b0, auto_rts_en_in = 1'b1;
  logic auto_cts_en_in = 1'b1, early_error_in = 1'b0, wake_irq_en_in = 1'b1;
  logic woke_in = 1'b0, xon_seen_in = 1'b0, xoff_seen_in = 1'b0, special_seen_in = 1'b0;
  logic rts_level_in = 1'b0, cts_pin_in = 1'b0;
  logic [3:0] modem_change_in = 4'h0, char_bits_in = 4'hA;
  logic [7:0] gpio_pin_in = 8'h00, gpio_irq_en_in = 8'h01, gpio_invert_in = 8'h00;
  logic [15:0] bit_ticks_in = 16'h0002;
  logic [7:0] irq_mask_out, irq_source_out, line_state_out;
  logic polled_mode_out, sleep_en_out, irq_out;
  uart_irq_ctrl #(.GPIO_W(8), .TIMER_W(16)) i_dut (.*);
  uart_host_model i_host (.clk_sys_in(clk_sys_in), .strobe_out(strobe_in), .wdata_out(wdata_in));
  always #25 clk_sys_in = ~clk_sys_in;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : cyc
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic code(input logic [5:0] exp);
    cyc(3);
    #1;
    chk({2'b00, irq_source_out[5:0]}, {2'b00, exp});
  endtask : code
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  task automatic t_mask();
    cyc(1);
    fifo_en_in <= 1'b0;
    cyc(2);
    #1;
    chk(irq_source_out, 8'h01);
    chk(irq_mask_out, 8'h00);
    cyc(1);
    fifo_en_in <= 1'b1;
    i_host.access(7'h40, 8'hFF);
    cyc(2);
    #1;
    chk(irq_mask_out, 8'h0F);
    chk({7'h00, polled_mode_out}, 8'h00);
    cyc(1);
    enhanced_en_in <= 1'b1;
    i_host.access(7'h40, 8'hF0);
    cyc(2);
    #1;
    chk({polled_mode_out, sleep_en_out, irq_mask_out[7:2]}, 8'hFC);
    $display("mask test done");
  endtask : t_mask
  task automatic t_prio();
    i_host.access(7'h40, 8'h0F);
    cyc(1);
    rx_in.overrun <= 1'b1;
    tx_in <= 3'h7;
    modem_change_in <= 4'h1;
    cyc(1);
    rx_in.overrun <= 1'b0;
    modem_change_in <= 4'h0;
    code(6'h06);
    chk(line_state_out, 8'h62);
    i_host.access(7'h10, 8'h00);
    code(6'h02);
    i_host.access(7'h20, 8'h00);
    code(6'h00);
    i_host.access(7'h08, 8'h00);
    code(6'h01);
    i_host.access(7'h40, 8'h00);
    i_host.access(7'h40, 8'h02);
    code(6'h02);
    i_host.access(7'h02, 8'h00);
    code(6'h01);
    $display("priority test done");
  endtask : t_prio
  task automatic t_rx();
    time t0;
    i_host.access(7'h40, 8'h01);
    cyc(1);
    rx_in <= 9'h180;
    t0 = $time;
    cyc(1);
    rx_in <= 9'h100;
    code(6'h04);
    chk({7'h00, line_state_out[0]}, 8'h01);
    cyc(1);
    rx_in <= 9'h000;
    for (int n = 0; n < 200 && irq_source_out[5:0] !== 6'h0C; n++) begin
      cyc(1);
      #1;
    end
    chk({7'h00, ($time - t0) / 50 >= TMO && ($time - t0) / 50 <= TMO + 8}, 8'h01);
    i_host.access(7'h04, 8'h00);
    code(6'h01);
    cyc(1);
    rx_in <= 9'h040;
    $display("receive test done");
  endtask : t_rx
  task automatic t_flow();
    i_host.access(7'h40, 8'hE0);
    cyc(1);
    xoff_seen_in <= 1'b1;
    cyc(1);
    xoff_seen_in <= 1'b0;
    code(6'h10);
    i_host.access(7'h20, 8'h00);
    code(6'h01);
    cyc(1);
    rts_level_in <= 1'b1;
    cyc(1);
    code(6'h20);
    i_host.access(7'h20, 8'h00);
    code(6'h20);
    i_host.access(7'h08, 8'h00);
    code(6'h01);
    cyc(1);
    woke_in <= 1'b1;
    cyc(1);
    woke_in <= 1'b0;
    code(6'h01);
    chk({7'h00, irq_out}, 8'h01);
    i_host.access(7'h20, 8'h00);
    code(6'h01);
    chk({7'h00, irq_out}, 8'h00);
    cyc(1);
    gpio_pin_in <= 8'h01;
    cyc(6);
    #1;
    chk(irq_source_out, 8'h81);
    chk({7'h00, irq_out}, 8'h01);
    i_host.access(7'h01, 8'h00);
    cyc(3);
    #1;
    chk(irq_source_out, 8'hC1);
    chk({7'h00, irq_out}, 8'h00);
    $display("flow and gpio test done");
  endtask : t_flow
  task automatic t_edge();
    i_host.access(7'h40, 8'h84);
    cyc(1);
    early_error_in <= 1'b1;
    rx_in <= 9'h082;
    cyc(1);
    rx_in <= 9'h000;
    code(6'h06);
    i_host.access(7'h10, 8'h00);
    code(6'h01);
    cyc(1);
    early_error_in <= 1'b0;
    rx_in <= 9'h040;
    cts_pin_in <= 1'b1;
    cyc(1);
    code(6'h20);
    i_host.access(7'h08, 8'h00);
    code(6'h01);
    $display("early error and cts test done");
  endtask : t_edge
  initial begin
    repeat (4000) @(posedge clk_sys_in);
    fails++;
    test_done();
  end
  initial begin
    cyc(8);
    rst_in <= 1'b0;
    t_mask();
    t_prio();
    t_rx();
    t_flow();
    t_edge();
    test_done();
  end
endmodule : uart_irq_ctrl_test
